// file: vcore_seq_pkg.sv
// constants shared by the core-voltage start-up sequencer
package vcore_seq_pkg;
	// clock rate and time base
	localparam int CLK_MHZ = 50; // system clock in MHz
	localparam int TICK_US = 1; // slew step interval in us
	localparam int TICK_CYC = TICK_US * CLK_MHZ; // cycles per slew step
	localparam int TICK_W = 6; // width of the tick counter
	// start-up timing
	localparam int POR_DELAY_US = 120; // on-request tied high delay, us
	localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
	localparam int POWER_GOOD_MS = 7; // power-good delay after start, ms
	localparam int POWER_GOOD_CYC = POWER_GOOD_MS * 1000 * CLK_MHZ;
	localparam int QUAL_CYCLES = 13; // pwm cycles in window to qualify
	// reference scale: one step is 1.25 mV
	localparam int REF_W = 11; // reference code width
	localparam int CODE_W = 7; // voltage code width
	localparam logic [REF_W-1:0] REF_MAX = 11'h4b0; // 1.5000 V
	localparam logic [REF_W-1:0] REF_BOOT = 11'h370; // 1.1 V boot level
	localparam logic [REF_W-1:0] REF_PER_CODE = 11'h00a; // 12.5 mV
	localparam logic [REF_W-1:0] REF_RESET = 11'h000; // zero at reset
	// slew steps per tick (1.25 mV each)
	localparam logic [3:0] STEP_BOOT = 4'h2; // 2.5 mV/us
	localparam logic [3:0] STEP_SLEW = 4'h4; // 5 mV/us
	localparam logic [3:0] STEP_FAST = 4'h8; // 10 mV/us
	// sequencer states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_soft = 3'b001,
		st_qual = 3'b010,
		st_slew = 3'b011,
		st_reg = 3'b100
	} seq_state_t;
endpackage

// file: phase_sequencer.sv
// steers master clock pulses to one or two phase clocks
`timescale 1ns/100ps
module phase_sequencer (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// control
	input wire logic run,
	input wire logic two_phase,
	input wire logic master_clock,
	// phase clocks
	output logic phase_one_clock,
	output logic phase_two_clock
);
	import vcore_seq_pkg::*;

	logic turn_two; // next pulse belongs to phase two

	// alternate pulses between phases, or all to phase one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			turn_two <= 1'b0;
			phase_one_clock <= 1'b0;
			phase_two_clock <= 1'b0;
		end else if (clk_en) begin
			phase_one_clock <= 1'b0;
			phase_two_clock <= 1'b0;
			if (!run || !two_phase) begin
				// single phase: phase two never clocked
				turn_two <= 1'b0;
				if (run && master_clock) begin
					phase_one_clock <= 1'b1;
				end
			end else if (master_clock) begin
				// half-period apart by alternation
				phase_one_clock <= !turn_two;
				phase_two_clock <= turn_two;
				turn_two <= !turn_two;
			end
		end
	end
endmodule

// file: vcore_startup_phase_sequencer.sv
// start-up sequencer, reference slew, pwm and gate control
`timescale 1ns/100ps
module vcore_startup_phase_sequencer #(
	parameter int POR_CYC = vcore_seq_pkg::POR_DELAY_CYC,
	parameter int PG_CYC = vcore_seq_pkg::POWER_GOOD_CYC,
	parameter int QUAL_N = vcore_seq_pkg::QUAL_CYCLES
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// supply and processor side
	input wire logic supply_ok,
	input wire logic regulator_on_request,
	input wire logic [vcore_seq_pkg::CODE_W-1:0] voltage_code,
	input wire logic deeper_sleep_request,
	// configuration
	input wire logic graphics_mode,
	input wire logic two_phase,
	input wire logic diode_emulation,
	// analog comparator results
	input wire logic output_in_window,
	input wire logic ramp_at_comp,
	input wire logic [1:0] ripple_at_window,
	input wire logic [1:0] phase_node_zero,
	// sequencer outputs
	output logic [vcore_seq_pkg::REF_W-1:0] reference,
	output logic downstream_clock_permit_n,
	output logic power_good,
	output logic [2:0] seq_state,
	// modulator and power stage
	output logic master_clock,
	output logic phase_one_clock,
	output logic phase_two_clock,
	output logic [1:0] pwm,
	output logic [1:0] low_side_gate
);
	import vcore_seq_pkg::*;

	// refuse delays and counts that the counters below cannot hold
	if (POR_CYC < 1 || POR_CYC > 8192 || PG_CYC < 1 || PG_CYC > 524288
		|| QUAL_N < 1 || QUAL_N > 255) begin : g_bad_param
		$error("vcore sequencer: bad timing parameter");
	end

	seq_state_t state; // sequencer state
	seq_state_t next_state; // its next value
	logic [12:0] por_count; // cycles since supply became ok
	logic por_settled; // supply-ok delay has elapsed
	logic [18:0] pg_count; // cycles since start
	logic [7:0] qual_count; // pwm cycles seen in window
	logic [TICK_W-1:0] tick_count; // slew time base
	logic tick; // one slew step due
	logic ramp_seen; // last sample of master ramp compare
	logic [REF_W-1:0] code_level; // level selected by voltage code
	logic [REF_W-1:0] goal; // level the reference heads for
	logic [3:0] step; // slew step per tick
	logic enabled; // supply and request both present
	logic at_goal; // reference equals goal
	logic qualified; // window held long enough
	logic running; // switching allowed
	logic [1:0] phase_clock; // per-phase set events
	logic [1:0] low_cut; // diode emulation cutoff per phase
	logic [REF_W-1:0] code_drop; // voltage code scaled to 12.5 mV

	assign enabled = supply_ok && regulator_on_request;
	assign phase_clock = {phase_two_clock, phase_one_clock};
	assign running = (state != st_idle);

	// voltage code to level: zero is 1.5 V, minus 12.5 mV a step
	always_comb begin
		code_drop = REF_W'({4'h0, voltage_code} * REF_PER_CODE);
		if (code_drop >= REF_MAX) begin
			code_level = REF_RESET;
		end else begin
			code_level = REF_MAX - code_drop;
		end
	end

	// goal and slew rate per state and mode
	always_comb begin
		goal = code_level;
		step = STEP_SLEW;
		if (state == st_soft || state == st_qual) begin
			if (graphics_mode) begin
				goal = code_level;
				step = deeper_sleep_request ? STEP_FAST : STEP_SLEW;
			end else begin
				goal = REF_BOOT;
				step = STEP_BOOT;
			end
		end
	end

	assign at_goal = (reference == goal);
	assign qualified = (qual_count >= 8'(QUAL_N));

	// supply-ok delay, also covers on request tied high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			por_count <= '0;
			por_settled <= 1'b0;
		end else if (clk_en) begin
			if (!supply_ok) begin
				por_count <= '0;
				por_settled <= 1'b0;
			end else if (!por_settled) begin
				por_count <= por_count + 13'h0001;
				if (por_count >= 13'(POR_CYC - 1)) begin
					por_settled <= 1'b1;
				end
			end
		end
	end

	// next sequencer state
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (enabled && por_settled) begin
					next_state = st_soft;
				end
			end
			st_soft: begin
				if (at_goal) begin
					next_state = st_qual;
				end
			end
			st_qual: begin
				if (qualified) begin
					// graphics already at code level
					next_state = graphics_mode ? st_reg : st_slew;
				end
			end
			st_slew: begin
				if (at_goal) begin
					next_state = st_reg;
				end
			end
			st_reg: begin
				next_state = st_reg;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		if (!enabled) begin
			next_state = st_idle;
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign seq_state = state;

	// slew time base: one step per microsecond
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else if (clk_en) begin
			tick <= 1'b0;
			if (!running || tick_count >= TICK_W'(TICK_CYC - 1)) begin
				tick_count <= '0;
				tick <= running;
			end else begin
				tick_count <= tick_count + TICK_W'(1);
			end
		end
	end

	// digital reference ramp toward the goal
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reference <= REF_RESET;
		end else if (clk_en) begin
			if (!running) begin
				reference <= REF_RESET;
			end else if (tick && !at_goal) begin
				if (reference < goal) begin
					if (goal - reference > REF_W'(step)) begin
						reference <= reference + REF_W'(step);
					end else begin
						reference <= goal;
					end
				end else begin
					if (reference - goal > REF_W'(step)) begin
						reference <= reference - REF_W'(step);
					end else begin
						reference <= goal;
					end
				end
			end
		end
	end

	// count pwm cycles with output inside the window
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			qual_count <= '0;
		end else if (clk_en) begin
			if (state != st_qual || !output_in_window) begin
				qual_count <= '0;
			end else if (master_clock && !qualified) begin
				qual_count <= qual_count + 8'h01;
			end
		end
	end

	// clock permit goes low once qualified, released on idle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			downstream_clock_permit_n <= 1'b1;
		end else if (clk_en) begin
			if (next_state == st_idle) begin
				downstream_clock_permit_n <= 1'b1;
			end else if (state == st_qual && qualified) begin
				downstream_clock_permit_n <= 1'b0;
			end
		end
	end

	// power good after fixed delay from start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pg_count <= '0;
			power_good <= 1'b0;
		end else if (clk_en) begin
			if (next_state == st_idle) begin
				pg_count <= '0;
				power_good <= 1'b0;
			end else if (!power_good) begin
				pg_count <= pg_count + 19'h00001;
				if (pg_count >= 19'(PG_CYC - 1)) begin
					power_good <= 1'b1;
				end
			end
		end
	end

	// one-shot master clock on ramp reaching compensation level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ramp_seen <= 1'b0;
			master_clock <= 1'b0;
		end else if (clk_en) begin
			ramp_seen <= ramp_at_comp;
			// pulse also restarts the ramp at the window level
			master_clock <= running && ramp_at_comp && !ramp_seen;
		end
	end

	// distribute master pulses to the phases
	phase_sequencer u_phase_sequencer (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.run(running),
		.two_phase(two_phase),
		.master_clock(master_clock),
		.phase_one_clock(phase_one_clock),
		.phase_two_clock(phase_two_clock)
	);

	// per-phase pwm pulse and low-side gate
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_phase
			// pwm set on phase clock, cleared at window level
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					pwm[i] <= 1'b0;
				end else if (clk_en) begin
					if (!running) begin
						pwm[i] <= 1'b0;
					end else if (phase_clock[i]) begin
						pwm[i] <= 1'b1;
					end else if (ripple_at_window[i]) begin
						pwm[i] <= 1'b0;
					end
				end
			end
			// cutoff latch: zero crossing ends low-side conduction
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					low_cut[i] <= 1'b0;
				end else if (clk_en) begin
					if (phase_clock[i] || !diode_emulation) begin
						low_cut[i] <= 1'b0;
					end else if (phase_node_zero[i] && !pwm[i]) begin
						low_cut[i] <= 1'b1;
					end
				end
			end
			// low-side gate on between pulses unless cut off
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					low_side_gate[i] <= 1'b0;
				end else if (clk_en) begin
					low_side_gate[i] <= running && !pwm[i] && !phase_clock[i]
						&& !low_cut[i]
						&& !(diode_emulation && phase_node_zero[i]);
				end
			end
		end
	endgenerate
endmodule

// file: cpu_side_model.sv
// processor side model: request, voltage code and sleep lines
`timescale 1ns/100ps
module cpu_side (
	// clock
	input wire logic clk,
	// processor lines
	output logic regulator_on_request,
	output logic [vcore_seq_pkg::CODE_W-1:0] voltage_code,
	output logic deeper_sleep_request
);
	import vcore_seq_pkg::*;
	// all lines low at power up
	initial begin
		regulator_on_request = 1'h0;
		voltage_code = 7'h00;
		deeper_sleep_request = 1'h0;
	end
	// raise the request with a code, just after an edge
	task on(input logic [CODE_W-1:0] c, input logic s);
		@(posedge clk);
		#1;
		voltage_code = c;
		deeper_sleep_request = s;
		regulator_on_request = 1'h1;
	endtask
	// drop the request
	task off;
		@(posedge clk);
		#1;
		regulator_on_request = 1'h0;
	endtask
endmodule

// file: vcore_seq_properties.sv
// port assertions for the start-up phase sequencer
`timescale 1ns/100ps
module vcore_seq_properties #(
	parameter int POR_CYC = 20,
	parameter int PG_CYC = 2000,
	parameter int QUAL_N = 13
) (
	// clock, reset
	input wire logic clk,
	input wire logic resetn,
	// control inputs
	input wire logic supply_ok,
	input wire logic regulator_on_request,
	input wire logic two_phase,
	input wire logic diode_emulation,
	input wire logic output_in_window,
	input wire logic ramp_at_comp,
	input wire logic [1:0] phase_node_zero,
	// outputs
	input wire logic downstream_clock_permit_n,
	input wire logic power_good,
	input wire logic [2:0] seq_state,
	input wire logic master_clock,
	input wire logic phase_one_clock,
	input wire logic phase_two_clock,
	input wire logic [1:0] pwm,
	input wire logic [1:0] low_side_gate
);
	logic [3:0] qcnt; // master pulses inside window
	logic [19:0] run; // cycles out of idle
	logic [15:0] sup; // cycles with supply up
	logic last_one; // last phase clock went to phase one
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// window qualification count
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) qcnt <= 4'h0;
		else if (seq_state == 3'h0 || !output_in_window) qcnt <= 4'h0;
		else if (master_clock && qcnt != 4'hf) qcnt <= qcnt + 4'h1;
	// time since leaving idle
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) run <= 20'h0;
		else if (seq_state == 3'h0) run <= 20'h0;
		else if (run != 20'hfffff) run <= run + 20'h1;
	// time since supply came up
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) sup <= 16'h0;
		else if (!supply_ok) sup <= 16'h0;
		else if (sup != 16'hffff) sup <= sup + 16'h1;
	// which phase took the last clock
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) last_one <= 1'h0;
		else if (!two_phase || seq_state == 3'h0) last_one <= 1'h0;
		else if (phase_one_clock) last_one <= 1'h1;
		else if (phase_two_clock) last_one <= 1'h0;
	sequence comp_edge;
		$rose(ramp_at_comp) && seq_state != 3'h0;
	endsequence
	sequence clocks_out;
		master_clock ##1 (phase_one_clock || phase_two_clock);
	endsequence
	master_pulse_a: assert property (comp_edge |=> clocks_out)
		else $error("master clock pulse missing");
	single_phase_a: assert property (!two_phase && master_clock |=>
		phase_one_clock && !phase_two_clock)
		else $error("single phase routing wrong");
	alternate_a: assert property (two_phase && phase_two_clock |->
		last_one)
		else $error("phase two clocked out of turn");
	pwm_start_a: assert property (phase_one_clock |=> pwm[0])
		else $error("pwm did not start");
	diode_cut_a: assert property (diode_emulation && low_side_gate[0] &&
		phase_node_zero[0] |=> !low_side_gate[0])
		else $error("low gate not cut at zero");
	permit_qual_a: assert property ($fell(downstream_clock_permit_n) |->
		qcnt >= QUAL_N && qcnt <= QUAL_N + 1 && $past(seq_state) == 3'h2)
		else $error("clock permit without qualification");
	power_good_time_a: assert property ($rose(power_good) |->
		run >= PG_CYC - 2 && run <= PG_CYC + 1)
		else $error("power good at wrong time");
	por_wait_a: assert property (seq_state == 3'h1 &&
		$past(seq_state) == 3'h0 |-> sup >= POR_CYC)
		else $error("start before supply delay");
	disable_a: assert property (!regulator_on_request || !supply_ok |=>
		seq_state == 3'h0 && !power_good && downstream_clock_permit_n)
		else $error("disable did not return to idle");
endmodule
bind vcore_startup_phase_sequencer vcore_seq_properties #(.POR_CYC(POR_CYC),
	.PG_CYC(PG_CYC), .QUAL_N(QUAL_N)) chk (.clk(clk), .resetn(resetn),
	.supply_ok(supply_ok), .regulator_on_request(regulator_on_request),
	.two_phase(two_phase), .diode_emulation(diode_emulation),
	.output_in_window(output_in_window), .ramp_at_comp(ramp_at_comp),
	.phase_node_zero(phase_node_zero), .power_good(power_good),
	.downstream_clock_permit_n(downstream_clock_permit_n),
	.seq_state(seq_state), .master_clock(master_clock), .pwm(pwm),
	.phase_one_clock(phase_one_clock), .phase_two_clock(phase_two_clock),
	.low_side_gate(low_side_gate));

// file: tb.sv
// self-checking bench for the start-up phase sequencer
`timescale 1ns/100ps
module tb;
	import vcore_seq_pkg::*;
	logic clk = 0, resetn = 0, supply_ok = 0, graphics_mode = 0;
	logic two_phase = 1, diode_emulation = 0, output_in_window = 0;
	logic ramp_at_comp = 0;
	logic [1:0] ripple_at_window = 2'h0, phase_node_zero = 2'h3;
	logic regulator_on_request, deeper_sleep_request, power_good;
	logic [CODE_W-1:0] voltage_code;
	logic [REF_W-1:0] reference;
	logic downstream_clock_permit_n, master_clock;
	logic phase_one_clock, phase_two_clock;
	logic [2:0] seq_state;
	logic [1:0] pwm, low_side_gate;
	int n_fail = 0, cmp_count = 0, cyc = 0, n1 = 0, n2 = 0, n;
	// 50 MHz clock
	always #10 clk = ~clk;
	cpu_side cpu (.clk(clk), .regulator_on_request(regulator_on_request),
		.voltage_code(voltage_code),
		.deeper_sleep_request(deeper_sleep_request));
	vcore_startup_phase_sequencer #(.POR_CYC(20), .PG_CYC(2000)) DUT (
		.clk(clk), .resetn(resetn), .clk_en(1'h1), .supply_ok(supply_ok),
		.regulator_on_request(regulator_on_request), .pwm(pwm),
		.voltage_code(voltage_code), .graphics_mode(graphics_mode),
		.deeper_sleep_request(deeper_sleep_request), .two_phase(two_phase),
		.diode_emulation(diode_emulation), .ramp_at_comp(ramp_at_comp),
		.output_in_window(output_in_window), .reference(reference),
		.ripple_at_window(ripple_at_window), .power_good(power_good),
		.phase_node_zero(phase_node_zero), .seq_state(seq_state),
		.downstream_clock_permit_n(downstream_clock_permit_n),
		.master_clock(master_clock), .phase_one_clock(phase_one_clock),
		.phase_two_clock(phase_two_clock), .low_side_gate(low_side_gate));
	// wait k edges, then drive just after
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// compare one value
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %0h got %0h", s, e, g);
		end
	endtask
	// wait for a reference level, cycles in n
	task wait_ref(input logic [REF_W-1:0] t);
		n = 0;
		while (reference !== t && n < 30000) begin
			step(1);
			n++;
		end
	endtask
	// comparator pulses: ramp at comp, later ripple at window
	task pulse(input int k);
		repeat (k) begin
			ramp_at_comp = 1'h1;
			step(1);
			ramp_at_comp = 1'h0;
			step(4);
			ripple_at_window = 2'h3;
			step(1);
			ripple_at_window = 2'h0;
			step(3);
		end
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// phase clock counts and run ceiling
	always @(posedge clk) begin
		n1 <= n1 + phase_one_clock;
		n2 <= n2 + phase_two_clock;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			stop_test;
		end
	end
	// main sequence
	initial begin
		step(10);
		resetn = 1'h1;
		chk("reset permit", 1, downstream_clock_permit_n);
		chk("reset ref", 0, reference);
		supply_ok = 1'h1;
		step(40);
		chk("no request", 0, seq_state);
		cpu.on(7'h00, 1'h0);
		step(3);
		chk("start", 1, seq_state);
		step(1986);
		chk("pg early", 0, power_good);
		step(20);
		chk("pg", 1, power_good);
		wait_ref(REF_BOOT);
		chk("boot time", 1, n > 19850 && n < 20150);
		step(2);
		chk("qual", 2, seq_state);
		output_in_window = 1'h1;
		pulse(6);
		output_in_window = 1'h0;
		step(1);
		output_in_window = 1'h1;
		pulse(12);
		chk("count cleared", 1, downstream_clock_permit_n);
		pulse(1);
		chk("permit", 0, downstream_clock_permit_n);
		chk("phase one", 10, n1);
		chk("phase two", 9, n2);
		wait_ref(REF_MAX - REF_PER_CODE * 11'h00);
		chk("slew time", 1, n > 3850 && n < 4100);
		step(100);
		chk("regulate", 4, seq_state);
		done("processor start");
		pulse(2);
		chk("gate on", 3, low_side_gate);
		diode_emulation = 1'h1;
		phase_node_zero = 2'h0;
		pulse(2);
		chk("de gate on", 3, low_side_gate);
		phase_node_zero = 2'h3;
		step(2);
		chk("gate cut", 0, low_side_gate);
		chk("pwm off", 0, pwm);
		two_phase = 1'h0;
		pulse(4);
		chk("single one", 16, n1);
		chk("single two", 11, n2);
		done("phases");
		cpu.off;
		step(2);
		chk("off state", 0, seq_state);
		chk("off pg", 0, power_good);
		chk("off permit", 1, downstream_clock_permit_n);
		done("disable");
		graphics_mode = 1'h1;
		output_in_window = 1'h0;
		cpu.on(7'h50, 1'h1);
		wait_ref(REF_MAX - REF_PER_CODE * 11'h50);
		chk("gfx time", 1, n > 2400 && n < 2650);
		step(2);
		chk("gfx qual", 2, seq_state);
		output_in_window = 1'h1;
		pulse(13);
		chk("gfx permit", 0, downstream_clock_permit_n);
		chk("gfx regulate", 4, seq_state);
		done("graphics");
		supply_ok = 1'h0;
		step(2);
		chk("supply lost", 0, seq_state);
		supply_ok = 1'h1;
		step(18);
		chk("por wait", 0, seq_state);
		step(4);
		chk("por start", 1, seq_state);
		done("tied request");
		cpu.off;
		step(2);
		cpu.on(7'h50, 1'h0);
		wait_ref(REF_MAX - REF_PER_CODE * 11'h50);
		chk("gfx slow", 1, n > 4900 && n < 5150);
		done("slow graphics");
		stop_test;
	end
endmodule
